// ===== hw/base_timer_pkg.sv
// constants shared by the free-running base timer and its helpers
package base_timer_pkg;
    // ------------------------------------------------------------
    // register offsets (word index on the plain register port)
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CTRL0  = 4'h0; // timer_control_first
    localparam logic [3:0] OFF_CTRL1  = 4'h1; // timer_control_second
    localparam logic [3:0] OFF_DIV    = 4'h2; // source_divider_reg
    localparam logic [3:0] OFF_CLRCMP = 4'h3; // clear_compare_reg
    localparam logic [3:0] OFF_OC0    = 4'h4; // out_compare_zero_reg
    localparam logic [3:0] OFF_COUNT  = 4'h5; // live_count_reg
    localparam logic [3:0] OFF_STATUS = 4'h6; // sticky events, write one to clear
    localparam logic [3:0] OFF_MASK   = 4'h7; // interrupt mask

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_LSB    = 0; // counting mode, two bits
    localparam int SRC_BIT     = 2; // 0: undivided clock, 1: halved clock
    localparam int OVF_SEL_BIT = 3; // 0: bit 14 carry, 1: bit 15 carry
    localparam int OC0_CLR_BIT = 4; // clear on compare channel zero
    localparam int EXT_CLR_BIT = 5; // clear on low external pin
    localparam int CTRL0_W     = 6;
    localparam int RUN_BIT     = 0; // count_run_bit
    localparam int ST_OVF_BIT  = 0; // overflow event
    localparam int ST_MATCH_BIT = 1; // clear compare match event
    localparam int ST_W        = 2;

    // ------------------------------------------------------------
    // mode codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  MODE_INC    = 2'h0;
    localparam logic [1:0]  MODE_UPDN   = 2'h1;
    localparam logic [1:0]  MODE_QUAD   = 2'h2;
    localparam logic [5:0]  CTRL0_RST   = 6'h00;
    localparam logic [7:0]  DIV_RST     = 8'h00;
    localparam logic [15:0] CLRCMP_RST  = 16'hFFFF;
    localparam logic [15:0] OC0_RST     = 16'hFFFF;
    localparam logic [1:0]  MASK_RST    = 2'h0;
    localparam logic [15:0] COUNT_CLEAR = 16'h0000;
    localparam logic [15:0] COUNT_TOP   = 16'hFFFF;
    localparam logic [14:0] LOW15_TOP   = 15'h7FFF;

    // up/down direction state, one-hot
    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } dir_t;
endpackage

// ===== hw/free_running_base_timer.sv
// sixteen-bit free-running base timer with register port and interrupt
// ------------------------------------------------------------
// Notes on behaviour
// - source divided by divider setting plus one
// - modes: increment, up/down, two-phase
// - writing run bit one starts counting
// - run bit zero stops, holds count cleared
// - match with clear compare clears count
// - compare channel zero match clears, if selected
// - low external clear pin clears, if selected
// - every clear loads 0x0000
// - bit 14 or 15 overflow raises interrupt
// - clear compare match raises interrupt
// - count reads live while running
// - running write replaces count, counting continues
// - count writes ignored while stopped
// - up/down: 0 to FFFF, back to 0
// - two-phase counts pulses on phase pins
// - two-phase counts every edge at divider setting zero, both directions
// ------------------------------------------------------------
`timescale 1ns/1ns
module free_running_base_timer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    output logic             irq,
    input  wire logic        phaseA,
    input  wire logic        phaseB,
    input  wire logic        extClearN
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [5:0]  ctrl0_r;  // mode, source, overflow select, clear enables
    logic        run_r;    // count_run_bit
    logic [7:0]  div_r;    // divider setting
    logic [15:0] cmp_r;    // clear compare value
    logic [15:0] oc0_r;    // compare channel zero value
    logic [15:0] cnt_r;    // live count
    logic [15:0] cnt_nxt;  // next count
    logic [7:0]  pre_r;    // prescaler position
    logic        half_r;   // halved clock phase
    logic [1:0]  status_r; // sticky events
    logic [1:0]  mask_r;   // interrupt enables
    logic [15:0] rdata_r;  // read answer
    logic        irq_r;    // interrupt level
    base_timer_pkg::dir_t dir_r;   // up/down direction state
    base_timer_pkg::dir_t dir_nxt; // its next value

    // ------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------
    logic [1:0] mode;     // counting mode
    logic       srcHalf;  // halved clock selected
    logic       ovfSel15; // overflow watched at bit 15
    logic       oc0En;    // compare channel zero clears
    logic       extEn;    // external pin clears
    logic       srcEvt;   // one undivided source event
    logic       tick;     // divided_count_source event
    logic       countUp;  // direction of this tick
    logic       matchCmp; // count equals clear compare
    logic       matchOc0; // count equals compare channel zero
    logic       clearNow; // any clear source active
    logic       cntWr;    // software writes the count
    logic       ovfEvt;   // selected carry occurs
    logic [1:0] stSet;    // events setting status this cycle

    quad_step_if qs ();

    assign mode     = ctrl0_r[base_timer_pkg::MODE_LSB +: 2];
    assign srcHalf  = ctrl0_r[base_timer_pkg::SRC_BIT];
    assign ovfSel15 = ctrl0_r[base_timer_pkg::OVF_SEL_BIT];
    assign oc0En    = ctrl0_r[base_timer_pkg::OC0_CLR_BIT];
    assign extEn    = ctrl0_r[base_timer_pkg::EXT_CLR_BIT];
    assign rdata    = rdata_r;
    assign irq      = irq_r;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // port write decode, used for every writable register
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    // one count step up or down, wrapping at sixteen bits
    function automatic logic [15:0] stepCount(input logic [15:0] c,
                                              input logic up);
        stepCount = up ? 16'(c + 16'h0001) : 16'(c - 16'h0001);
    endfunction

    // ------------------------------------------------------------
    // quadrature decoder
    // ------------------------------------------------------------
    quad_decoder u_quad (
        .clk    (clk),
        .rst    (rst),
        .phaseA (phaseA),
        .phaseB (phaseB),
        .stepIf (qs.dec)
    );

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl0_r <= base_timer_pkg::CTRL0_RST;
            run_r   <= 1'b0;
            div_r   <= base_timer_pkg::DIV_RST;
            cmp_r   <= base_timer_pkg::CLRCMP_RST;
            oc0_r   <= base_timer_pkg::OC0_RST;
            mask_r  <= base_timer_pkg::MASK_RST;
        end else if (wr) begin
            if (hit(addr, base_timer_pkg::OFF_CTRL0)) begin
                ctrl0_r <= wdata[5:0];
            end
            if (hit(addr, base_timer_pkg::OFF_CTRL1)) begin
                run_r <= wdata[base_timer_pkg::RUN_BIT];
            end
            if (hit(addr, base_timer_pkg::OFF_DIV)) begin
                div_r <= wdata[7:0];
            end
            if (hit(addr, base_timer_pkg::OFF_CLRCMP)) begin
                cmp_r <= wdata;
            end
            if (hit(addr, base_timer_pkg::OFF_OC0)) begin
                oc0_r <= wdata;
            end
            if (hit(addr, base_timer_pkg::OFF_MASK)) begin
                mask_r <= wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // count source and prescaler
    // ------------------------------------------------------------
    // halved clock runs free so its phase does not depend on start time
    always_ff @(posedge clk) begin
        if (rst) begin
            half_r <= 1'b0;
        end else begin
            half_r <= ~half_r;
        end
    end

    always_comb begin
        if (mode == base_timer_pkg::MODE_QUAD) begin
            srcEvt = qs.step;
        end else begin
            srcEvt = srcHalf ? half_r : 1'b1;
        end
    end

    // divide by setting plus one; setting zero passes every event
    assign tick = run_r && srcEvt && (pre_r == div_r);

    always_ff @(posedge clk) begin
        if (rst || !run_r) begin
            pre_r <= 8'h00;
        end else if (srcEvt) begin
            pre_r <= (pre_r == div_r) ? 8'h00 : 8'(pre_r + 8'h01);
        end
    end

    // ------------------------------------------------------------
    // direction
    // ------------------------------------------------------------
    // up/down: turn at the top and at zero; neither end value repeats
    always_comb begin
        dir_nxt = dir_r;
        countUp = 1'b1;
        case (mode)
            base_timer_pkg::MODE_UPDN: begin
                case (dir_r)
                    base_timer_pkg::DIR_UP: begin
                        countUp = (cnt_r != base_timer_pkg::COUNT_TOP);
                    end
                    base_timer_pkg::DIR_DOWN: begin
                        countUp = (cnt_r == base_timer_pkg::COUNT_CLEAR);
                    end
                    default: begin
                        countUp = 1'b1;
                    end
                endcase
                if (tick) begin
                    dir_nxt = countUp ? base_timer_pkg::DIR_UP
                                      : base_timer_pkg::DIR_DOWN;
                end
            end
            base_timer_pkg::MODE_QUAD: begin
                countUp = qs.up;
            end
            default: begin
                countUp = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || !run_r || (mode != base_timer_pkg::MODE_UPDN)) begin
            dir_r <= base_timer_pkg::DIR_UP;
        end else if (clearNow) begin
            dir_r <= base_timer_pkg::DIR_UP;
        end else begin
            dir_r <= dir_nxt;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    assign matchCmp = (cnt_r == cmp_r);
    assign matchOc0 = (cnt_r == oc0_r);
    assign clearNow = run_r && (matchCmp
                             || (oc0En && matchOc0)
                             || (extEn && !extClearN));
    assign cntWr    = run_r && wr && hit(addr, base_timer_pkg::OFF_COUNT);

    // a clear outranks a write in the same cycle; the write is then lost
    always_comb begin
        if (!run_r) begin
            cnt_nxt = base_timer_pkg::COUNT_CLEAR;
        end else if (clearNow) begin
            cnt_nxt = base_timer_pkg::COUNT_CLEAR;
        end else if (cntWr) begin
            cnt_nxt = wdata;
        end else if (tick) begin
            cnt_nxt = stepCount(cnt_r, countUp);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= base_timer_pkg::COUNT_CLEAR;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // events, status and interrupt
    // ------------------------------------------------------------
    // only upward carries count; a borrow is not an overflow
    assign ovfEvt = tick && countUp && !clearNow && !cntWr
                 && (ovfSel15 ? (cnt_r == base_timer_pkg::COUNT_TOP)
                              : (cnt_r[14:0] == base_timer_pkg::LOW15_TOP));

    always_comb begin
        stSet = 2'h0;
        stSet[base_timer_pkg::ST_OVF_BIT]   = ovfEvt;
        stSet[base_timer_pkg::ST_MATCH_BIT] = run_r && matchCmp;
    end

    // a new event wins over a write-one clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            status_r <= 2'h0;
        end else if (wr && hit(addr, base_timer_pkg::OFF_STATUS)) begin
            status_r <= (status_r & ~wdata[1:0]) | stSet;
        end else begin
            status_r <= status_r | stSet;
        end
    end

    // registered level, so it follows status by one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // data stand for one cycle only; unmapped reads answer zero
    always_ff @(posedge clk) begin
        if (rst || !rd) begin
            rdata_r <= 16'h0000;
        end else begin
            case (addr)
                base_timer_pkg::OFF_CTRL0:  rdata_r <= {10'h000, ctrl0_r};
                base_timer_pkg::OFF_CTRL1:  rdata_r <= {15'h0, run_r};
                base_timer_pkg::OFF_DIV:    rdata_r <= {8'h00, div_r};
                base_timer_pkg::OFF_CLRCMP: rdata_r <= cmp_r;
                base_timer_pkg::OFF_OC0:    rdata_r <= oc0_r;
                base_timer_pkg::OFF_COUNT:  rdata_r <= cnt_r;
                base_timer_pkg::OFF_STATUS: rdata_r <= {14'h0, status_r};
                base_timer_pkg::OFF_MASK:   rdata_r <= {14'h0, mask_r};
                default:                    rdata_r <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_stop_holds_zero :
    assert property (@(posedge clk) disable iff (rst)
        !run_r ##1 !run_r |-> cnt_r == 16'h0000)
        else $error("count not held at zero while stopped");

    a_write_stopped :
    assert property (@(posedge clk) disable iff (rst)
        !run_r && wr && addr == 4'h5 && wdata != 16'h0000 |=> cnt_r == 16'h0000)
        else $error("count write took effect while stopped");

    a_start_counts :
    assert property (@(posedge clk) disable iff (rst)
        run_r && mode == 2'h0 && !srcHalf && div_r == 8'h00 && !clearNow
        && !cntWr |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
        else $error("running undivided count did not increment");

    a_cmp_clear :
    assert property (@(posedge clk) disable iff (rst)
        run_r && cnt_r == cmp_r |=> cnt_r == 16'h0000 && status_r[1])
        else $error("clear compare match did not clear and flag");

    a_oc0_clear :
    assert property (@(posedge clk) disable iff (rst)
        run_r && oc0En && cnt_r == oc0_r |=> cnt_r == 16'h0000)
        else $error("compare channel zero match did not clear");

    a_ext_clear :
    assert property (@(posedge clk) disable iff (rst)
        run_r && extEn && !extClearN |=> cnt_r == 16'h0000)
        else $error("low external pin did not clear");

    a_count_write :
    assert property (@(posedge clk) disable iff (rst)
        run_r && wr && addr == 4'h5 && !clearNow |=> cnt_r == $past(wdata))
        else $error("running count write not taken");

    a_ovf_flag :
    assert property (@(posedge clk) disable iff (rst)
        tick && mode == 2'h0 && ovfSel15 && cnt_r == 16'hFFFF && !clearNow
        && !cntWr |=> status_r[0] && cnt_r == 16'h0000)
        else $error("bit 15 overflow not flagged");

    a_irq_follows :
    assert property (@(posedge clk) disable iff (rst)
        run_r && cnt_r == cmp_r && mask_r[1] ##1 mask_r[1] |=> irq)
        else $error("masked-in match did not raise interrupt");

    a_updown_turn :
    assert property (@(posedge clk) disable iff (rst)
        tick && mode == 2'h1 && dir_r == base_timer_pkg::DIR_UP
        && cnt_r == 16'hFFFF && !clearNow && !cntWr |=> cnt_r == 16'hFFFE)
        else $error("up/down did not turn at the top");

    a_div_spacing :
    assert property (@(posedge clk) disable iff (rst)
        tick && div_r == 8'h02 && mode == 2'h0 && !srcHalf ##1 run_r
        && div_r == 8'h02 |-> !tick ##1 !tick ##1 (tick || !run_r))
        else $error("divide by three spacing wrong");
endmodule

// ===== hw/quad_decoder.sv
// four-edge quadrature decoder for the two phase pins
`timescale 1ns/1ns
module quad_decoder (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  phaseA,
    input  wire logic  phaseB,
    quad_step_if.dec   stepIf
);
    logic prevA_r; // phase a one cycle ago
    logic prevB_r; // phase b one cycle ago
    logic aMoved;  // phase a changed
    logic bMoved;  // phase b changed

    assign aMoved = phaseA ^ prevA_r;
    assign bMoved = phaseB ^ prevB_r;

    // ------------------------------------------------------------
    // history of the pins
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            prevA_r <= 1'b0;
            prevB_r <= 1'b0;
        end else begin
            prevA_r <= phaseA;
            prevB_r <= phaseB;
        end
    end

    // ------------------------------------------------------------
    // step and direction
    // ------------------------------------------------------------
    // a leading b gives phaseA != old b on every edge; both pins moving at
    // once is an illegal jump and is dropped rather than guessed
    always_ff @(posedge clk) begin
        if (rst) begin
            stepIf.step <= 1'b0;
            stepIf.up   <= 1'b1;
        end else begin
            stepIf.step <= aMoved ^ bMoved;
            if (aMoved ^ bMoved) begin
                stepIf.up <= phaseA ^ prevB_r;
            end
        end
    end
endmodule

// ===== hw/quad_step_if.sv
// step and direction carried from the quadrature decoder to the counter
`timescale 1ns/1ns
interface quad_step_if;
    logic step; // one-cycle pulse per decoded edge
    logic up;   // direction of that edge, high for increment
    modport dec (output step, output up);
    modport tmr (input step, input up);
endinterface

// ===== tb/quad_encoder_model.sv
// behavioural encoder and clear-pin source facing the base timer
`timescale 1ns/1ns
module quad_encoder_model (
    input  wire logic clk,
    input  wire logic stepReq,
    input  wire logic stepUp,
    input  wire logic clrReq,
    output logic      phaseA,
    output logic      phaseB,
    output logic      extClearN
);
    logic [1:0] pos_r; // quadrature position, gray-encoded onto the pins below

    // ----------------------------------------
    // one quadrature edge per request
    // ----------------------------------------
    // one pin moves per step, so no double change
    initial pos_r = 2'h0;
    always @(posedge clk) begin
        if (stepReq) begin
            pos_r <= stepUp ? pos_r + 2'h1 : pos_r - 2'h1;
        end
    end
    assign phaseA    = pos_r[1] ^ pos_r[0]; // a leads b when stepping up
    assign phaseB    = pos_r[1];
    assign extClearN = ~clrReq;            // pulled up unless asked low
endmodule

// ===== tb/tb.sv
// self-checking bench for the free-running base timer
`timescale 1ns/1ns
module tb;
    logic        clk;         // 100 MHz clock
    logic        rst;         // synchronous reset
    logic [3:0]  addr;        // register word index
    logic [15:0] wdata;       // write data
    logic        wr;          // write strobe
    logic        rd;          // read strobe
    logic [15:0] rdata;       // read data
    logic        irq;         // level interrupt
    logic        phaseA;      // encoder phase a
    logic        phaseB;      // encoder phase b
    logic        extClearN;   // external clear, low active
    logic        stepReq;     // one encoder edge wanted
    logic        stepUp;      // its direction
    logic        clrReq;      // hold the clear pin low
    int          miscompares; // mismatches seen
    int          compares;    // comparisons made
    int          cycles;      // watchdog
    logic [15:0] got [8];     // burst read results
    logic [15:0] ctl;         // control word of a case
    logic [15:0] cc;          // clear compare of a case
    logic [15:0] oc;          // compare zero of a case
    int          mdl;         // behavioural count
    bit          mup;         // behavioural up/down direction
    bit          hit;         // behavioural clear compare match
    int          n;
    // ctrl0, clear compare, compare zero, start count
    logic [63:0] tbl [4] = '{64'h0000_8000_FFFF_0000, 64'h0000_0040_FFFF_003E,
                             64'h0010_8000_0040_003E, 64'h0001_0010_FFFF_FFFC};
    logic [15:0] rstv [9] = '{16'h0, 16'h0, 16'h0, 16'hFFFF, 16'hFFFF, 16'h0, 16'h0,
                              16'h0, 16'h0};

    free_running_base_timer uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .phaseA(phaseA), .phaseB(phaseB),
        .extClearN(extClearN));
    quad_encoder_model enc (.clk(clk), .stepReq(stepReq), .stepUp(stepUp),
        .clrReq(clrReq), .phaseA(phaseA), .phaseB(phaseB), .extClearN(extClearN));

    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_of_test;
        if (miscompares == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    // back-to-back reads; each result is picked up just after its edge
    task automatic rburst(input logic [3:0] a, input int k);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        for (int i = 0; i < k; i++) begin
            @(posedge clk);
            if (i == k - 1) rd <= 1'b0;
            #1 got[i] = rdata;
        end
    endtask
    // one count tick of the reference model
    task automatic mstep;
        if (mdl == cc || (ctl[4] && mdl == oc)) begin
            hit = hit | (mdl == cc);
            mdl = 0;
            mup = 1;
        end else if (ctl[1:0] != 2'h1) mdl = (mdl + 1) & 16'hFFFF;
        else begin
            mup = mup ? (mdl != 16'hFFFF) : (mdl == 0);
            mdl = mup ? mdl + 1 : mdl - 1;
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 16'h0;
        stepReq = 1'b0; stepUp = 1'b0; clrReq = 1'b0;
        miscompares = 0; compares = 0; cycles = 0;
        n = $urandom(32'h1EA9);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped word reads zero
        for (int a = 0; a < 9; a++) begin
            rburst(4'(a), 1);
            chk(got[0], rstv[a]);
        end
        wreg(base_timer_pkg::OFF_COUNT, 16'h1234);
        rburst(base_timer_pkg::OFF_COUNT, 1);
        chk(got[0], 16'h0000);
        // rate over a whole number of divided periods, both sources
        for (int s = 0; s < 2; s++) begin
            n = $urandom_range(3);
            wreg(base_timer_pkg::OFF_DIV, 16'(n));
            wreg(base_timer_pkg::OFF_CTRL0, 16'(s << base_timer_pkg::SRC_BIT));
            wreg(base_timer_pkg::OFF_CTRL1, 16'h0001);
            rburst(base_timer_pkg::OFF_COUNT, 1);
            mdl = got[0];
            repeat (8 * (n + 1) * (s + 1) - 2) @(posedge clk);
            rburst(base_timer_pkg::OFF_COUNT, 1);
            chk(got[0], 16'(mdl + 8));
            wreg(base_timer_pkg::OFF_CTRL1, 16'h0000);
        end
        wreg(base_timer_pkg::OFF_DIV, 16'h0000);
        wreg(base_timer_pkg::OFF_MASK, 16'h0002);
        // live writes, clear sources and up/down turn against the model
        for (int e = 0; e < 4; e++) begin
            {ctl, cc, oc} = tbl[e][63:16];
            mdl = (e == 0) ? $urandom_range(16'h6FFF) : tbl[e][15:0];
            mup = 1;
            hit = 0;
            wreg(base_timer_pkg::OFF_STATUS, 16'h0003);
            wreg(base_timer_pkg::OFF_CTRL0, ctl);
            wreg(base_timer_pkg::OFF_CLRCMP, cc);
            wreg(base_timer_pkg::OFF_OC0, oc);
            wreg(base_timer_pkg::OFF_CTRL1, 16'h0001);
            wreg(base_timer_pkg::OFF_COUNT, 16'(mdl));
            rburst(base_timer_pkg::OFF_COUNT, 8);
            for (int i = 0; i < 8; i++) begin
                mstep();
                chk(got[i], 16'(mdl));
            end
            rburst(base_timer_pkg::OFF_STATUS, 1);
            chk(got[0], hit ? 16'h0002 : 16'h0000);
            chk({15'h0, irq}, {15'h0, hit});
            wreg(base_timer_pkg::OFF_CTRL1, 16'h0000);
        end
        // overflow select: bit 14 carry, bit 14 carry with bit 15 selected (no flag), then bit 15 carry
        wreg(base_timer_pkg::OFF_CLRCMP, 16'h0100);
        for (int e = 0; e < 3; e++) begin
            mdl = (e == 2) ? 16'hFFFD : 16'h7FFD;
            wreg(base_timer_pkg::OFF_STATUS, 16'h0003);
            wreg(base_timer_pkg::OFF_MASK, 16'h0001);
            wreg(base_timer_pkg::OFF_CTRL0, (e == 0) ? 16'h0000 : 16'h0008);
            wreg(base_timer_pkg::OFF_CTRL1, 16'h0001);
            wreg(base_timer_pkg::OFF_COUNT, 16'(mdl));
            repeat (6) @(posedge clk);
            rburst(base_timer_pkg::OFF_STATUS, 1);
            chk(got[0], (e == 1) ? 16'h0000 : 16'h0001);
            chk({15'h0, irq}, (e == 1) ? 16'h0000 : 16'h0001);
            wreg(base_timer_pkg::OFF_MASK, 16'h0000);
            rburst(base_timer_pkg::OFF_STATUS, 1);
            chk({15'h0, irq}, 16'h0000);
            wreg(base_timer_pkg::OFF_CTRL1, 16'h0000);
        end
        // low external pin, selected or not; clear beats the write
        for (int e = 0; e < 2; e++) begin
            wreg(base_timer_pkg::OFF_CTRL0, 16'(e << base_timer_pkg::EXT_CLR_BIT));
            clrReq <= 1'b1;
            wreg(base_timer_pkg::OFF_CTRL1, 16'h0001);
            wreg(base_timer_pkg::OFF_COUNT, 16'h0200);
            rburst(base_timer_pkg::OFF_COUNT, 1);
            chk(got[0], e ? 16'h0000 : 16'h0201);
            clrReq <= 1'b0;
            wreg(base_timer_pkg::OFF_CTRL1, 16'h0000);
            rburst(base_timer_pkg::OFF_COUNT, 1);
            chk(got[0], 16'h0000);
        end
        // random quadrature walk, every edge counted
        wreg(base_timer_pkg::OFF_CTRL0, 16'(base_timer_pkg::MODE_QUAD));
        wreg(base_timer_pkg::OFF_CLRCMP, 16'h8000);
        wreg(base_timer_pkg::OFF_CTRL1, 16'h0001);
        mdl = 0;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            stepReq <= 1'b1;
            stepUp  <= $urandom_range(1);
            @(posedge clk);
            stepReq <= 1'b0;
            mdl = stepUp ? mdl + 1 : mdl - 1;
            repeat (2) @(posedge clk);
        end
        repeat (3) @(posedge clk);
        rburst(base_timer_pkg::OFF_COUNT, 1);
        chk(got[0], 16'(mdl));
        end_of_test();
    end
endmodule
